// ===== logic/regulator_vbus_pkg.sv
// package for the regulator and bus-supply detect block
// assumes a 32-bit apb slave with word-aligned registers
package regulator_vbus_pkg;
  localparam int ADDR_W = 12;
  // register byte offsets
  localparam logic [11:0] REGULATOR_CONTROL_OFF = 12'h000;
  localparam logic [11:0] IRQ_STATUS_OFF = 12'h004;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h008;
  localparam logic [11:0] RESET_SOURCE_OFF = 12'h00C;
  // regulator control field positions
  localparam int OFF_BIT_POS = 7;
  localparam int LEVEL_BIT_POS = 6;
  localparam int POL_BIT_POS = 5;
  localparam int LOW_POWER_BIT_POS = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WRITABLE = 8'hB0; // bits 7,5,4; low nibble reads zero
  // event status layout
  localparam int EV_ATTACH_POS = 0;
  localparam int EV_DETACH_POS = 1;
  localparam int EV_MATCH_POS = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic regulator_off_bit;
    logic bus_supply_polarity_select;
    logic regulator_low_power_select;
  } control_t;

  localparam control_t CONTROL_T_RESET = '{1'b0, 1'b0, 1'b0};
endpackage

// ===== logic/level_sync.sv
// two-flop synchroniser for one asynchronous level
// assumes the destination clock is the block clock
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic sync_o
);
  logic [STAGES-1:0] chain_q;
  // only the last stage is read outside this chain
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], async_i};
    end
  end
  assign sync_o = chain_q[STAGES-1];
endmodule
`default_nettype wire

// ===== logic/edge_event.sv
// rising and falling edge pulse detector on a synchronised level
// assumes the input is already in the block clock domain
`timescale 1ns/1ps
`default_nettype none
module edge_event (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  output logic rise_o,
  output logic fall_o
);
  logic prev_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level_i;
    end
  end
  assign rise_o = level_i & ~prev_q;
  assign fall_o = ~level_i & prev_q;
endmodule
`default_nettype wire

// ===== logic/regulator_vbus_detect_control.sv
// regulator control and bus-supply detection with apb registers
// assumes one 250 MHz clock, synchronous active-low reset, vbus pin asynchronous
// assumes software keeps the low control nibble at zero; it reads zero regardless
// limitation: a pin pulse shorter than one clock period may be missed entirely
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module regulator_vbus_detect_control
  import regulator_vbus_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // bus supply pin
  input wire logic BUS_SUPPLY_I,
  // regulator and system outputs
  output logic REGULATOR_ENABLE_O,
  output logic REGULATOR_LOW_POWER_O,
  output logic BUS_SUPPLY_MATCH_IRQ_O,
  output logic SYSTEM_RESET_REQ_O,
  output logic IRQ_O
);

  control_t ctrl_q;
  logic reset_source_q;
  logic [EV_W-1:0] status_q;
  logic [EV_W-1:0] mask_q;
  logic level_sync;
  logic rise;
  logic fall;
  logic match;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic [EV_W-1:0] events;
  logic [7:0] ctrl_byte;
  // register selects, decoded once and shared by every register process
  logic sel_control;
  logic sel_status;
  logic sel_mask;
  logic sel_source;
  logic setup;
  logic lane0;
  logic ctrl_wr;
  logic mask_wr;
  logic source_wr;
  logic status_clr;
  // next values and views shared by the read path and the output flops
  logic [EV_W-1:0] status_d;
  logic [EV_W-1:0] status_view;
  logic [EV_W-1:0] pending;
  logic [31:0] rdata_d;
  logic ready_d;
  logic slverr_d;
  logic regulator_enable_d;
  logic low_power_d;
  logic match_irq_d;
  logic reset_req_d;
  logic irq_d;

  // pin crosses into the clock domain before anything looks at it
  level_sync #(.STAGES(SYNC_STAGES)) u_sync (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .async_i(BUS_SUPPLY_I),
    .sync_o(level_sync)
  );

  edge_event u_edge (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .level_i(level_sync),
    .rise_o(rise),
    .fall_o(fall)
  );

  // polarity 1 matches high level, 0 matches low level
  always_comb begin
    if (ctrl_q.bus_supply_polarity_select) begin
      match = level_sync;
    end else begin
      match = ~level_sync;
    end
  end

  // apb decode: zero wait states, write lands in the access cycle
  assign access = PSEL_I & PENABLE_I;
  assign wr = access & PWRITE_I;
  assign rd = access & ~PWRITE_I;
  assign mapped = (PADDR_I == REGULATOR_CONTROL_OFF) || (PADDR_I == IRQ_STATUS_OFF) ||
                  (PADDR_I == IRQ_MASK_OFF) || (PADDR_I == RESET_SOURCE_OFF);

  // one-hot register selects; anything else is answered with an error
  assign sel_control = (PADDR_I == REGULATOR_CONTROL_OFF);
  assign sel_status = (PADDR_I == IRQ_STATUS_OFF);
  assign sel_mask = (PADDR_I == IRQ_MASK_OFF);
  assign sel_source = (PADDR_I == RESET_SOURCE_OFF);
  // setup cycle is where read data and the answer are prepared
  assign setup = PSEL_I & ~PENABLE_I;
  assign lane0 = PSTRB_I[0]; // only byte lane 0 carries register bits

  // write strobes; a write with lane 0 masked off changes nothing
  assign ctrl_wr = wr & lane0 & sel_control;
  assign mask_wr = wr & lane0 & sel_mask;
  assign source_wr = wr & lane0 & sel_source;
  // a status read clears in the access cycle, after the setup cycle captured it
  assign status_clr = rd & sel_status;

  // control byte view; low nibble is hard zero
  always_comb begin
    ctrl_byte = 8'h00;
    ctrl_byte[OFF_BIT_POS] = ctrl_q.regulator_off_bit;
    ctrl_byte[LEVEL_BIT_POS] = level_sync;
    ctrl_byte[POL_BIT_POS] = ctrl_q.bus_supply_polarity_select;
    ctrl_byte[LOW_POWER_BIT_POS] = ctrl_q.regulator_low_power_select;
  end

  // control register writes; status bit is not writable
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      ctrl_q <= CONTROL_T_RESET;
    end else if (ctrl_wr) begin
      ctrl_q.regulator_off_bit <= PWDATA_I[OFF_BIT_POS];
      ctrl_q.bus_supply_polarity_select <= PWDATA_I[POL_BIT_POS];
      ctrl_q.regulator_low_power_select <= PWDATA_I[LOW_POWER_BIT_POS];
    end
  end

  // reset-source select, off by default so a detach cannot reset the chip
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      reset_source_q <= 1'b0;
    end else if (source_wr) begin
      reset_source_q <= PWDATA_I[0];
    end
  end

  // interrupt mask
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      mask_q <= EV_RESET;
    end else if (mask_wr) begin
      mask_q <= PWDATA_I[EV_W-1:0];
    end
  end

  // sticky edge events plus a live match bit that is never latched
  always_comb begin
    events = EV_RESET;
    events[EV_ATTACH_POS] = rise;
    events[EV_DETACH_POS] = fall;
  end

  // read clears; an event in the clearing cycle survives
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      status_q <= EV_RESET;
    end else begin
      status_q <= status_d; // set wins over the read clear
    end
  end

  // next status: a read clears, but an event landing in the same cycle is kept
  always_comb begin
    if (status_clr) begin
      status_d = events;
    end else begin
      status_d = status_q | events;
    end
  end

  // what software sees: sticky bits plus this cycle's events, live match on top
  always_comb begin
    status_view = status_q | events; // an event in the setup cycle is reported, not lost
    status_view[EV_MATCH_POS] = match;
  end

  // unmasked sources for the summary interrupt line
  assign pending = status_view & mask_q;

  // read data chosen in the setup cycle; registered so it stands through the access cycle
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (setup && !PWRITE_I) begin
      case (PADDR_I)
        REGULATOR_CONTROL_OFF: rdata_d = {24'h00_0000, ctrl_byte};
        IRQ_STATUS_OFF: rdata_d = {29'h0000_0000, status_view};
        IRQ_MASK_OFF: rdata_d = {29'h0000_0000, mask_q};
        RESET_SOURCE_OFF: rdata_d = {31'h0000_0000, reset_source_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // zero wait states: the answer always comes in the access cycle
  assign ready_d = setup;
  // unmapped offsets are refused with an error; writes to them change nothing
  assign slverr_d = setup & ~mapped;

  // the off bit is active high while the enable pin is active high, hence the inversion
  assign regulator_enable_d = ~ctrl_q.regulator_off_bit;
  assign low_power_d = ctrl_q.regulator_low_power_select;
  // match outputs hold no sticky state, so their flops fall one edge after the match ends
  assign match_irq_d = match & mask_q[EV_MATCH_POS];
  assign reset_req_d = match & reset_source_q;
  assign irq_d = |pending;

  // read data, valid while ready is high
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else begin
      PRDATA_O <= rdata_d;
    end
  end

  // ready pulse, one cycle after the setup edge
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      PREADY_O <= 1'b0;
    end else begin
      PREADY_O <= ready_d;
    end
  end

  // error pulse rides with ready
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      PSLVERR_O <= 1'b0;
    end else begin
      PSLVERR_O <= slverr_d;
    end
  end

  // regulator on out of reset, so a cold start is powered
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      REGULATOR_ENABLE_O <= 1'b1;
    end else begin
      REGULATOR_ENABLE_O <= regulator_enable_d;
    end
  end

  // low-power select, normal mode after reset
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      REGULATOR_LOW_POWER_O <= 1'b0;
    end else begin
      REGULATOR_LOW_POWER_O <= low_power_d;
    end
  end

  // match interrupt, one flop behind the synchronised level
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      BUS_SUPPLY_MATCH_IRQ_O <= 1'b0;
    end else begin
      BUS_SUPPLY_MATCH_IRQ_O <= match_irq_d;
    end
  end

  // reset request; the source bit is off by default
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      SYSTEM_RESET_REQ_O <= 1'b0;
    end else begin
      SYSTEM_RESET_REQ_O <= reset_req_d;
    end
  end

  // summary interrupt over sticky events and the live match
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= irq_d;
    end
  end

endmodule
`default_nettype wire

// ===== verification/vbus_host.sv
// upstream supply source that drives the bus-supply pin
// assumes requests are spaced wider than its largest delay
`timescale 1ns/1ps
`default_nettype none
module vbus_host (
  input wire logic level_i,
  input wire logic [3:0] delay_i,
  output logic vbus_o
);
  // slow or prompt answer, never aligned to the clock
  initial vbus_o = 1'b0;
  always @(level_i) vbus_o <= #(delay_i + 0.3) level_i;
endmodule
`default_nettype wire

// ===== verification/reg_vbus_sva.sv
// port checker for the regulator and bus-supply block
// assumes it is bound to the top module
`timescale 1ns/1ps
`default_nettype none
module reg_vbus_sva
  import regulator_vbus_pkg::*;
(
  // apb side
  input wire logic REF_CLK_I, RESET_N_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I, PRDATA_O,
  input wire logic [3:0] PSTRB_I,
  // pin and outputs
  input wire logic BUS_SUPPLY_I, REGULATOR_ENABLE_O, REGULATOR_LOW_POWER_O, BUS_SUPPLY_MATCH_IRQ_O,
  input wire logic SYSTEM_RESET_REQ_O, IRQ_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // completed control access
  wire logic ctl = PSEL_I && PENABLE_I && PREADY_O && PADDR_I == REGULATOR_CONTROL_OFF;
  wire logic wr = ctl && PWRITE_I && PSTRB_I[0];
  // idle bus and still pin, so levels must have settled
  sequence s_q; (!PSEL_I && $stable(BUS_SUPPLY_I))[*4]; endsequence
  property p_off; wr |=> ##1 REGULATOR_ENABLE_O == !$past(PWDATA_I[OFF_BIT_POS], 2); endproperty
  a_off: assert property (p_off) else $error("enable wrong");
  property p_lp; wr |=> ##1 REGULATOR_LOW_POWER_O == $past(PWDATA_I[LOW_POWER_BIT_POS], 2); endproperty
  a_lp: assert property (p_lp) else $error("low power wrong");
  property p_res; ctl && !PWRITE_I |-> PRDATA_O[3:0] == 4'h0; endproperty
  a_res: assert property (p_res) else $error("low nibble set");
  property p_lvl; $stable(BUS_SUPPLY_I)[*4] ##0 (ctl && !PWRITE_I) |-> PRDATA_O[LEVEL_BIT_POS] == BUS_SUPPLY_I;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level bit wrong");
  property p_hold; s_q ##1 (!PSEL_I && $stable(BUS_SUPPLY_I)) |=> $stable(BUS_SUPPLY_MATCH_IRQ_O); endproperty
  a_hold: assert property (p_hold) else $error("match moved");
  // match high, then the pin flips: request gone three edges on
  sequence s_flip; s_q ##1 (!PSEL_I && $changed(BUS_SUPPLY_I)); endsequence
  property p_drop; s_flip ##0 BUS_SUPPLY_MATCH_IRQ_O ##1 (!PSEL_I && $stable(BUS_SUPPLY_I))[*2] |=>
    !BUS_SUPPLY_MATCH_IRQ_O; endproperty
  a_drop: assert property (p_drop) else $error("match stuck");
  property p_rst; s_flip ##0 SYSTEM_RESET_REQ_O ##1 (!PSEL_I && $stable(BUS_SUPPLY_I))[*2] |=>
    !SYSTEM_RESET_REQ_O; endproperty
  a_rst: assert property (p_rst) else $error("reset stuck");
  property p_irq; BUS_SUPPLY_MATCH_IRQ_O |-> IRQ_O; endproperty
  a_irq: assert property (p_irq) else $error("irq low");
  c_rd: cover property (ctl && !PWRITE_I);
  c_drop: cover property (s_flip ##0 BUS_SUPPLY_MATCH_IRQ_O);
  c_err: cover property (PSLVERR_O);
endmodule
bind regulator_vbus_detect_control reg_vbus_sva u_sva (.*);
`default_nettype wire

// ===== verification/regulator_vbus_detect_control_test.sv
// self-checking bench for the regulator and bus-supply block
// assumes package, design, host model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module regulator_vbus_detect_control_test;
  import regulator_vbus_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, want = 0;
  logic pready, pslverr, pin, en, lp, mirq, sreq, irq;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, s = 32'h0000_005F;
  logic [32:0] q[$];
  int err_total = 0, samples_checked = 0;
  regulator_vbus_detect_control u_dut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .BUS_SUPPLY_I(pin), .REGULATOR_ENABLE_O(en), .REGULATOR_LOW_POWER_O(lp),
    .BUS_SUPPLY_MATCH_IRQ_O(mirq), .SYSTEM_RESET_REQ_O(sreq), .IRQ_O(irq));
  vbus_host u_host (.level_i(want), .delay_i(s[3:0]), .vbus_o(pin));
  initial forever #2 clk = ~clk;
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one apb transfer; a read leaves its expected word in the queue
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!pready && n < 20);
    if (!pready) begin
      err_total++;
      report_and_stop();
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // read data checked at the edge that accepts it
  always @(posedge clk) if (pready && psel && !pwr) chk({pslverr, prdata}, q.pop_front());
  initial begin
    logic [31:0] d;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(33'({en, lp, mirq, sreq, irq}), 33'h0_0000_0010);
    for (int i = 0; i < 6; i++) begin
      d = xs() & 32'h0000_00FF;
      apb(1'b1, REGULATOR_CONTROL_OFF, d, '0);
      repeat (2) @(posedge clk);
      chk(33'({en, lp}), 33'({~d[7], d[4]}));
      apb(1'b0, REGULATOR_CONTROL_OFF, '0, 33'(d & 32'h0000_00B0));
    end
    apb(1'b1, IRQ_MASK_OFF, 32'h0000_0004, '0);
    apb(1'b1, RESET_SOURCE_OFF, 32'h0000_0001, '0);
    // every polarity against every pin level, flips made while the bus is idle
    for (int i = 0; i < 4; i++) begin
      repeat (5) @(posedge clk);
      want <= i[0];
      repeat (6) @(posedge clk);
      apb(1'b1, REGULATOR_CONTROL_OFF, 32'(i[1]) << POL_BIT_POS, '0);
      repeat (8) @(posedge clk);
      chk(33'({mirq, sreq, irq}), {30'h0, {3{i[0] == i[1]}}});
      apb(1'b0, IRQ_STATUS_OFF, '0, 33'({i[0] == i[1], i == 2, i[0]}));
    end
    // sticky detach raises the line, one read drops it, the cleared mask hides the later attach
    apb(1'b1, IRQ_MASK_OFF, 32'h0000_0003, '0);
    want <= 1'b0;
    repeat (8) @(posedge clk);
    chk(33'(irq), 33'h0_0000_0001);
    apb(1'b0, IRQ_STATUS_OFF, '0, 33'h0_0000_0002);
    @(posedge clk); // the clear lands in the access cycle, the line falls one edge later
    chk(33'(irq), 33'h0_0000_0000);
    apb(1'b1, IRQ_MASK_OFF, '0, '0);
    want <= 1'b1;
    repeat (8) @(posedge clk);
    chk(33'({mirq, irq}), 33'h0_0000_0000);
    apb(1'b0, 12'h010, '0, 33'h1_0000_0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
